/* rtl/cbd_pkg.sv */
`default_nettype none
package cbd_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_DST     = 8'h04;
    localparam logic [7:0] REG_SRC     = 8'h08;
    localparam logic [7:0] REG_PTR     = 8'h0c;
    localparam logic [7:0] REG_PC      = 8'h10;
    localparam logic [7:0] REG_DISP    = 8'h14;
    localparam logic [7:0] REG_FLAGS   = 8'h18;
    localparam logic [7:0] REG_SYSMODE = 8'h1c;
    localparam logic [7:0] REG_PEND    = 8'h20;
    localparam logic [7:0] REG_MASK    = 8'h24;

    // Control register fields
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_OP_MSB   = 2;
    localparam int CTRL_SUB_BIT  = 3;
    localparam int CTRL_BUSY_BIT = 8;

    // Condition flag positions
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam int FLG_V = 4;
    localparam int FLG_D = 3;
    localparam int FLG_H = 2;

    localparam int SYM_IE_BIT = 0;

    // Reset values
    localparam logic [7:0]  RST_FLAGS   = 8'h00;
    localparam logic [7:0]  RST_SYSMODE = 8'h00;
    localparam logic [15:0] RST_PC      = 16'h0000;

    // Execution cycle counts
    localparam logic [4:0] CYC_BR_TAKEN = 5'd18;
    localparam logic [4:0] CYC_BR_NOT   = 5'd16;
    localparam logic [4:0] CYC_DIV_ZERO = 5'd10;
    localparam logic [4:0] CYC_DIV      = 5'd26;
    localparam logic [4:0] CYC_BCD      = 5'd4;
    localparam logic [4:0] CYC_DEC      = 5'd4;
    localparam logic [4:0] CYC_WORD_DECREMENT_OP     = 5'd8;
    localparam logic [4:0] CYC_IRQ_OFF  = 5'd4;

    localparam logic [4:0] DIV_STEPS = 5'd16;

    // Decimal adjust addends
    localparam logic [3:0] ADJ_NIB = 4'h6;
    localparam logic [7:0] ADJ_A0  = 8'ha0;
    localparam logic [7:0] ADJ_9A  = 8'h9a;
    localparam logic [7:0] ADJ_FA  = 8'hfa;

    typedef enum logic [2:0] {
        idle_op               = 3'b000,
        cmp_inc_branch_ne_op  = 3'b001,
        bcd_adjust_op         = 3'b010,
        byte_decrement_op     = 3'b011,
        word_decrement_op     = 3'b100,
        global_irq_off_op     = 3'b101,
        div_unsigned_op       = 3'b110,
        spare_op              = 3'b111
    } cbd_op_t;

    typedef enum logic {
        st_idle = 1'b0,
        st_run  = 1'b1
    } cbd_state_t;

endpackage : cbd_pkg
`default_nettype wire

/* rtl/cbd_div_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cbd_div_if;
    logic        start;
    logic [15:0] dividend;
    logic [7:0]  divisor;
    logic        done;
    logic [15:0] quot;
    logic [7:0]  rem;

    modport master (output start, output dividend, output divisor,
                    input done, input quot, input rem);
    modport slave  (input start, input dividend, input divisor,
                    output done, output quot, output rem);
endinterface : cbd_div_if
`default_nettype wire

/* rtl/cbd_div.sv */
`timescale 1ns/1ns
`default_nettype none
module cbd_div (
    input  wire logic pclk,
    input  wire logic presetn,
    cbd_div_if.slave  bus
);
    logic        busy_r,  busy_nxt;
    logic        done_r,  done_nxt;
    logic [4:0]  cnt_r,   cnt_nxt;
    logic [7:0]  dvs_r,   dvs_nxt;
    logic [7:0]  rem_r,   rem_nxt;
    logic [15:0] quo_r,   quo_nxt;
    logic [8:0]  trial;

    // Restoring divide, one quotient bit per clock
    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        dvs_nxt  = dvs_r;
        rem_nxt  = rem_r;
        quo_nxt  = quo_r;
        trial    = {rem_r, quo_r[15]};
        if (bus.start) begin
            busy_nxt = 1'b1;
            cnt_nxt  = cbd_pkg::DIV_STEPS;
            dvs_nxt  = bus.divisor;
            rem_nxt  = 8'h00;
            quo_nxt  = bus.dividend;
        end else if (busy_r) begin
            if (trial >= {1'b0, dvs_r}) begin
                rem_nxt = 8'((trial - {1'b0, dvs_r}));
                quo_nxt = {quo_r[14:0], 1'b1};
            end else begin
                rem_nxt = trial[7:0];
                quo_nxt = {quo_r[14:0], 1'b0};
            end
            cnt_nxt = cnt_r - 5'd1;
            if (cnt_r == 5'd1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r  <= 5'd0;
            dvs_r  <= 8'h00;
            rem_r  <= 8'h00;
            quo_r  <= 16'h0000;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cnt_r  <= cnt_nxt;
            dvs_r  <= dvs_nxt;
            rem_r  <= rem_nxt;
            quo_r  <= quo_nxt;
        end
    end

    assign bus.done = done_r;
    assign bus.quot = quo_r;
    assign bus.rem  = rem_r;
endmodule : cbd_div
`default_nettype wire

/* rtl/cbd_exec_top.sv */
// What this block does
// RULE1 - Not-equal compare adds signed byte displacement (+127..-128) to program counter
// RULE2 - Not-equal compare always increments the source pointer by one
// RULE3 - Adjust after add adds 00/06/60/66; carry set when 60 or 66 added
// RULE4 - Adjust after subtract adds 00, A0 or 9A by carry, half-carry, nibbles; code adds FA on half-carry without carry, ignores nibbles
// RULE5 - Adjust result undefined unless operand came from valid BCD arithmetic
// RULE6 - Adjust sets carry, zero, sign; overflow undefined; decimal, half-carry kept
// RULE7 - Byte decrement subtracts one; updates zero, sign, overflow; keeps C, D, H
// RULE8 - Word decrement treats even byte and next byte as one 16-bit value
// RULE9 - Word decrement updates zero, sign, overflow on 16 bits; keeps C, D, H
// RULE10 - Software should test word result by OR of bytes, not zero flag
// RULE11 - Interrupt disable clears system mode bit zero, flags unchanged
// RULE12 - While disabled, sources still set pending bits but nothing is serviced
// RULE13 - Software disables interrupts before touching mask, pending or source control
// RULE14 - Divide 16-bit by 8-bit; quotient to low byte, remainder to high byte
// RULE15 - Divide sets overflow on quotient of 256 or more, or zero divisor
// RULE16 - Divide sets carry only with overflow and quotient 256..511
// RULE17 - Divide zero on zero divisor or quotient, sign from quotient bit 7
// RULE18 - Divide takes 10 cycles on zero divisor, otherwise 26
// RULE19 - Not-equal compare takes 16 cycles not taken, 18 cycles taken
`timescale 1ns/1ns
`default_nettype none
module cbd_exec_top #(
    parameter int IRQ_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [IRQ_W-1:0]  irq_src,
    output logic                   irq_service,
    output logic                   exec_busy
);
    cbd_div_if div_bus ();

    cbd_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (div_bus.slave)
    );

    cbd_pkg::cbd_state_t state_r, state_nxt;
    cbd_pkg::cbd_op_t    op_r,    op_nxt;
    logic                sub_r,       sub_nxt;
    logic [4:0]          cnt_r,       cnt_nxt;
    logic [15:0]         dst_r,       dst_nxt;
    logic [7:0]          src_r,       src_nxt;
    logic [7:0]          ptr_r,       ptr_nxt;
    logic [15:0]         pc_r,        pc_nxt;
    logic [7:0]          disp_r,      disp_nxt;
    logic [7:0]          flags_r,     flags_nxt;
    logic [7:0]          sysmode_r,   sysmode_nxt;
    logic [IRQ_W-1:0]    pend_r,      pend_nxt;
    logic [IRQ_W-1:0]    mask_r,      mask_nxt;
    logic [IRQ_W-1:0]    irq_meta_r;
    logic [IRQ_W-1:0]    irq_sync_r;
    logic [31:0]         prdata_r,    prdata_nxt;
    logic                pready_r,    pready_nxt;
    logic                pslverr_r,   pslverr_nxt;
    logic                service_r,   service_nxt;
    logic                dstart_r,    dstart_nxt;

    logic                setup;
    logic                wr;
    logic                start;
    logic                taken;
    logic                div_zero;
    logic [31:0]         rd_data;
    logic [8:0]          bcd_res;
    logic [7:0]          dec8;
    logic [15:0]         dec16;
    logic [15:0]         quo;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            cbd_pkg::REG_CTRL, cbd_pkg::REG_DST, cbd_pkg::REG_SRC,
            cbd_pkg::REG_PTR, cbd_pkg::REG_PC, cbd_pkg::REG_DISP,
            cbd_pkg::REG_FLAGS, cbd_pkg::REG_SYSMODE, cbd_pkg::REG_PEND,
            cbd_pkg::REG_MASK: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    endfunction : mapped

    // Returns {carry, adjusted byte}
    function automatic logic [8:0] bcd_fix(input logic [7:0] v, input logic c,
                                           input logic h, input logic sub);
        logic       lo_big;
        logic       hi_big;
        logic       hi_up;
        logic [7:0] add;
        logic       cy;
        lo_big = v[3:0] > 4'h9;
        hi_big = v[7:4] > 4'h9;
        hi_up  = c | hi_big | ((v[7:4] == 4'h9) & lo_big);
        if (sub) begin
            if (c) begin
                add = h ? cbd_pkg::ADJ_9A : cbd_pkg::ADJ_A0; // RULE4
            end else begin
                add = h ? cbd_pkg::ADJ_FA : 8'h00; // RULE4
            end
            cy = c;
        end else begin
            add = {hi_up ? cbd_pkg::ADJ_NIB : 4'h0,
                   (h | lo_big) ? cbd_pkg::ADJ_NIB : 4'h0}; // RULE3
            cy  = hi_up; // RULE3
        end
        bcd_fix = {cy, 8'(v + add)};
    endfunction : bcd_fix

    // Applies carry, zero, sign and overflow; decimal and half-carry kept
    function automatic logic [7:0] set_czsv(input logic [7:0] f, input logic c,
                                            input logic z, input logic s,
                                            input logic v);
        logic [7:0] r;
        r              = f;
        r[cbd_pkg::FLG_C] = c;
        r[cbd_pkg::FLG_Z] = z;
        r[cbd_pkg::FLG_S] = s;
        r[cbd_pkg::FLG_V] = v;
        set_czsv       = r;
    endfunction : set_czsv

    function automatic logic [4:0] run_cycles(input cbd_pkg::cbd_op_t op,
                                              input logic tk, input logic dz);
        case (op)
            cbd_pkg::cmp_inc_branch_ne_op:
                run_cycles = tk ? cbd_pkg::CYC_BR_TAKEN : cbd_pkg::CYC_BR_NOT; // RULE19
            cbd_pkg::div_unsigned_op:
                run_cycles = dz ? cbd_pkg::CYC_DIV_ZERO : cbd_pkg::CYC_DIV; // RULE18
            cbd_pkg::bcd_adjust_op:     run_cycles = cbd_pkg::CYC_BCD;
            cbd_pkg::byte_decrement_op: run_cycles = cbd_pkg::CYC_DEC;
            cbd_pkg::word_decrement_op: run_cycles = cbd_pkg::CYC_WORD_DECREMENT_OP;
            cbd_pkg::global_irq_off_op: run_cycles = cbd_pkg::CYC_IRQ_OFF;
            default:                    run_cycles = 5'd0;
        endcase
    endfunction : run_cycles

    always_comb begin
        setup    = psel & ~penable;
        wr       = psel & penable & pready_r & pwrite;
        taken    = dst_r[7:0] != src_r;
        div_zero = src_r == 8'h00;
        bcd_res  = bcd_fix(dst_r[7:0], flags_r[cbd_pkg::FLG_C],
                           flags_r[cbd_pkg::FLG_H], sub_r);
        dec8     = dst_r[7:0] - 8'h01;
        dec16    = dst_r - 16'h0001;
        quo      = div_bus.quot;

        rd_data = 32'h0000_0000;
        case (paddr)
            cbd_pkg::REG_CTRL: begin
                rd_data[cbd_pkg::CTRL_OP_MSB:cbd_pkg::CTRL_OP_LSB] = op_r;
                rd_data[cbd_pkg::CTRL_SUB_BIT]  = sub_r;
                rd_data[cbd_pkg::CTRL_BUSY_BIT] = state_r == cbd_pkg::st_run;
            end
            cbd_pkg::REG_DST:     rd_data[15:0]      = dst_r;
            cbd_pkg::REG_SRC:     rd_data[7:0]       = src_r;
            cbd_pkg::REG_PTR:     rd_data[7:0]       = ptr_r;
            cbd_pkg::REG_PC:      rd_data[15:0]      = pc_r;
            cbd_pkg::REG_DISP:    rd_data[7:0]       = disp_r;
            cbd_pkg::REG_FLAGS:   rd_data[7:0]       = flags_r;
            cbd_pkg::REG_SYSMODE: rd_data[7:0]       = sysmode_r;
            cbd_pkg::REG_PEND:    rd_data[IRQ_W-1:0] = pend_r;
            cbd_pkg::REG_MASK:    rd_data[IRQ_W-1:0] = mask_r;
            default:              rd_data            = 32'h0000_0000;
        endcase

        pready_nxt  = setup;
        pslverr_nxt = setup & ~mapped(paddr);
        prdata_nxt  = (setup & ~pwrite) ? rd_data : 32'h0000_0000;

        state_nxt   = state_r;
        op_nxt      = op_r;
        sub_nxt     = sub_r;
        cnt_nxt     = cnt_r;
        dst_nxt     = dst_r;
        src_nxt     = src_r;
        ptr_nxt     = ptr_r;
        pc_nxt      = pc_r;
        disp_nxt    = disp_r;
        flags_nxt   = flags_r;
        sysmode_nxt = sysmode_r;
        mask_nxt    = mask_r;
        dstart_nxt  = 1'b0;
        start       = 1'b0;

        // Pending: hardware set wins over software write-one clear
        pend_nxt = pend_r & ~((wr && paddr == cbd_pkg::REG_PEND) ?
                              pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}});
        pend_nxt = pend_nxt | irq_sync_r; // RULE12

        if (wr) begin
            case (paddr)
                cbd_pkg::REG_CTRL: begin
                    if (state_r == cbd_pkg::st_idle) begin
                        op_nxt  = cbd_pkg::cbd_op_t'(
                                  pwdata[cbd_pkg::CTRL_OP_MSB:cbd_pkg::CTRL_OP_LSB]);
                        sub_nxt = pwdata[cbd_pkg::CTRL_SUB_BIT];
                        start   = 1'b1;
                    end
                end
                cbd_pkg::REG_DST:     dst_nxt     = pwdata[15:0];
                cbd_pkg::REG_SRC:     src_nxt     = pwdata[7:0];
                cbd_pkg::REG_PTR:     ptr_nxt     = pwdata[7:0];
                cbd_pkg::REG_PC:      pc_nxt      = pwdata[15:0];
                cbd_pkg::REG_DISP:    disp_nxt    = pwdata[7:0];
                cbd_pkg::REG_FLAGS:   flags_nxt   = pwdata[7:0];
                cbd_pkg::REG_SYSMODE: sysmode_nxt = pwdata[7:0];
                cbd_pkg::REG_MASK:    mask_nxt    = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        unique case (state_r)
            cbd_pkg::st_idle: begin
                if (start && run_cycles(op_nxt, taken, div_zero) != 5'd0) begin
                    state_nxt  = cbd_pkg::st_run;
                    cnt_nxt    = run_cycles(op_nxt, taken, div_zero);
                    dstart_nxt = (op_nxt == cbd_pkg::div_unsigned_op) & ~div_zero;
                end
            end
            cbd_pkg::st_run: begin
                cnt_nxt = cnt_r - 5'd1;
                if (cnt_r == 5'd1) begin
                    state_nxt = cbd_pkg::st_idle;
                    case (op_r)
                        cbd_pkg::cmp_inc_branch_ne_op: begin
                            if (taken) begin
                                pc_nxt = pc_r + {{8{disp_r[7]}}, disp_r}; // RULE1
                            end
                            ptr_nxt = ptr_r + 8'h01; // RULE2
                        end
                        cbd_pkg::bcd_adjust_op: begin
                            dst_nxt[7:0] = bcd_res[7:0]; // RULE5
                            flags_nxt = set_czsv(flags_r, bcd_res[8], bcd_res[7:0] == 8'h00,
                                                 bcd_res[7],
                                                 flags_r[cbd_pkg::FLG_V]); // RULE6
                        end
                        cbd_pkg::byte_decrement_op: begin
                            dst_nxt[7:0] = dec8; // RULE7
                            flags_nxt = set_czsv(flags_r, flags_r[cbd_pkg::FLG_C],
                                                 dec8 == 8'h00, dec8[7],
                                                 dst_r[7:0] == 8'h80); // RULE7
                        end
                        cbd_pkg::word_decrement_op: begin
                            dst_nxt = dec16; // RULE8
                            flags_nxt = set_czsv(flags_r, flags_r[cbd_pkg::FLG_C],
                                                 dec16 == 16'h0000, dec16[15],
                                                 dst_r == 16'h8000); // RULE9
                        end
                        cbd_pkg::global_irq_off_op: begin
                            sysmode_nxt[cbd_pkg::SYM_IE_BIT] = 1'b0; // RULE11
                        end
                        cbd_pkg::div_unsigned_op: begin
                            if (div_zero) begin
                                flags_nxt = set_czsv(flags_r, 1'b0, 1'b1, 1'b0,
                                                     1'b1); // RULE15
                            end else begin
                                dst_nxt   = {div_bus.rem, quo[7:0]}; // RULE14
                                flags_nxt = set_czsv(flags_r,
                                                     (quo[15:8] != 8'h00) &
                                                     (quo[15:9] == 7'h00), // RULE16
                                                     quo == 16'h0000, // RULE17
                                                     quo[7],
                                                     quo[15:8] != 8'h00); // RULE15
                            end
                        end
                        default: ;
                    endcase
                end
            end
        endcase

        service_nxt = sysmode_r[cbd_pkg::SYM_IE_BIT] & (|(pend_r & mask_r)); // RULE12
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= cbd_pkg::st_idle;
            op_r       <= cbd_pkg::idle_op;
            sub_r      <= 1'b0;
            cnt_r      <= 5'd0;
            dst_r      <= 16'h0000;
            src_r      <= 8'h00;
            ptr_r      <= 8'h00;
            pc_r       <= cbd_pkg::RST_PC;
            disp_r     <= 8'h00;
            flags_r    <= cbd_pkg::RST_FLAGS;
            sysmode_r  <= cbd_pkg::RST_SYSMODE;
            pend_r     <= '0;
            mask_r     <= '0;
            irq_meta_r <= '0;
            irq_sync_r <= '0;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            service_r  <= 1'b0;
            dstart_r   <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            op_r       <= op_nxt;
            sub_r      <= sub_nxt;
            cnt_r      <= cnt_nxt;
            dst_r      <= dst_nxt;
            src_r      <= src_nxt;
            ptr_r      <= ptr_nxt;
            pc_r       <= pc_nxt;
            disp_r     <= disp_nxt;
            flags_r    <= flags_nxt;
            sysmode_r  <= sysmode_nxt;
            pend_r     <= pend_nxt;
            mask_r     <= mask_nxt;
            irq_meta_r <= irq_src;
            irq_sync_r <= irq_meta_r;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            service_r  <= service_nxt;
            dstart_r   <= dstart_nxt;
        end
    end

    assign div_bus.start    = dstart_r;
    assign div_bus.dividend = dst_r;
    assign div_bus.divisor  = src_r;

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign irq_service = service_r;
    assign exec_busy   = state_r == cbd_pkg::st_run;
endmodule : cbd_exec_top
`default_nettype wire

/* testbench/cbd_exec_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cbd_exec_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq_service,
    input wire logic        exec_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] busy_cnt_r;
    logic [4:0] busy_cnt_nxt;
    always_comb begin
        busy_cnt_nxt = exec_busy ? busy_cnt_r + 5'h01 : 5'h00;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_r <= 5'h00;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_unmapped: assert property (pready && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access without error");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_busy_length: assert property ($fell(exec_busy) |->
        busy_cnt_r inside {5'h04, 5'h08, 5'h0a, 5'h10, 5'h12, 5'h1a})
        else $error("busy span of wrong length");
    a_busy_cause: assert property ($rose(exec_busy) |->
        $past(psel && penable && pwrite && paddr == 8'h00))
        else $error("busy without control write");
    a_irq_off: assert property (psel && penable && pready && pwrite &&
        paddr == 8'h1c && !pwdata[0] |-> ##2 !irq_service)
        else $error("service while globally disabled");
    c_branch: cover property ($fell(exec_busy) && busy_cnt_r == 5'h12);
    c_div_zero: cover property ($fell(exec_busy) && busy_cnt_r == 5'h0a);
    c_err: cover property (pslverr);
endmodule : cbd_exec_checker
bind cbd_exec_top cbd_exec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_service(irq_service), .exec_busy(exec_busy));
`default_nettype wire

/* testbench/cbd_exec_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cbd_exec_top_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  irq_src;
    logic        irq_service;
    logic        exec_busy;
    logic [31:0] rd;
    logic        err;
    int          mismatches;
    int          num_checks;
    logic [7:0]  br_dst[3] = '{8'h02, 8'h04, 8'h05};
    logic [7:0]  br_disp[3] = '{8'h80, 8'h7f, 8'h7f};
    logic [19:0] bcd[11] = '{20'h04242, 20'h03c42, 20'h1a505, 20'h19a00, 20'h3a208,
        20'h52585, 20'h52b91, 20'h73298, 20'h83131, 20'hd8525, 20'hf7f19};
    logic [39:0] dec[7] = '{40'h32000000ff, 40'h3400010000, 40'h310080007f,
        40'h4400010000, 40'h4180007fff, 40'h420000ffff, 40'h40010000ff};
    logic [43:0] dv[7] = '{44'h1003400340_0, 44'h0003800300_4, 44'h00ff0100ff_2,
        44'h01ff010000_b, 44'h0200010000_1, 44'h0100010000_9, 44'h1234000000_5};
    logic [15:0] pc;
    cbd_exec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(irq_src), .irq_service(irq_service),
        .exec_busy(exec_busy));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // Setup, access, then hold until ready is sampled at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc
    task automatic run_op(input logic [3:0] ctl, input int n_exp);
        int n;
        n = 0;
        wr(cbd_pkg::REG_CTRL, {28'h0, ctl});
        @(negedge pclk);
        while (exec_busy === 1'b1 && n < 100) begin
            n++;
            @(negedge pclk);
        end
        chk(32'(n), 32'(n_exp));
    endtask : run_op
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_src} = '0;
        mismatches = 0;
        num_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc(cbd_pkg::REG_FLAGS, 32'h0);
        rc(cbd_pkg::REG_SYSMODE, 32'h0);
        rc(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        pc = 16'h0100;
        wr(cbd_pkg::REG_PC, {16'h0, pc});
        wr(cbd_pkg::REG_PTR, 32'h3);
        wr(cbd_pkg::REG_SRC, 32'h4);
        wr(cbd_pkg::REG_FLAGS, 32'hfc);
        for (int i = 0; i < 3; i++) begin
            wr(cbd_pkg::REG_DST, {24'h0, br_dst[i]});
            wr(cbd_pkg::REG_DISP, {24'h0, br_disp[i]});
            if (i != 1) pc = pc + {{8{br_disp[i][7]}}, br_disp[i]};
            run_op(4'h1, (i != 1) ? 18 : 16);
            rc(cbd_pkg::REG_PC, {16'h0, pc});
            rc(cbd_pkg::REG_PTR, 32'(4 + i));
            rc(cbd_pkg::REG_FLAGS, 32'hfc);
        end
        foreach (bcd[i]) begin
            wr(cbd_pkg::REG_FLAGS, {24'h0, bcd[i][18], 3'h0, 1'b1, bcd[i][17], 2'h0});
            wr(cbd_pkg::REG_DST, {24'h0, bcd[i][15:8]});
            run_op({bcd[i][19], 3'h2}, 4);
            rc(cbd_pkg::REG_DST, {24'h0, bcd[i][7:0]});
            xfer(1'b0, cbd_pkg::REG_FLAGS, 32'h0);
            chk(rd & 32'hef, {24'h0, bcd[i][16], bcd[i][7:0] == 8'h0, bcd[i][7],
                2'b01, bcd[i][17], 2'h0});
        end
        foreach (dec[i]) begin
            wr(cbd_pkg::REG_FLAGS, 32'h8c);
            wr(cbd_pkg::REG_DST, {16'h0, dec[i][31:16]});
            run_op(dec[i][39:36], (dec[i][39:36] == 4'h3) ? 4 : 8);
            xfer(1'b0, cbd_pkg::REG_DST, 32'h0);
            chk(rd & ((dec[i][39:36] == 4'h3) ? 32'hff : 32'hffff),
                {16'h0, dec[i][15:0]});
            rc(cbd_pkg::REG_FLAGS, {24'h0, 1'b1, dec[i][34:32], 4'hc});
        end
        foreach (dv[i]) begin
            wr(cbd_pkg::REG_FLAGS, 32'h0c);
            wr(cbd_pkg::REG_DST, {16'h0, dv[i][43:28]});
            wr(cbd_pkg::REG_SRC, {24'h0, dv[i][27:20]});
            run_op(4'h6, (dv[i][27:20] == 8'h0) ? 10 : 26);
            rc(cbd_pkg::REG_FLAGS, {24'h0, dv[i][3:0], 4'hc});
            xfer(1'b0, cbd_pkg::REG_DST, 32'h0);
            if (!dv[i][0]) chk(rd, {16'h0, dv[i][19:4]});
        end
        wr(cbd_pkg::REG_MASK, 32'h1);
        wr(cbd_pkg::REG_SYSMODE, 32'h1);
        wr(cbd_pkg::REG_FLAGS, 32'hfc);
        @(posedge pclk);
        irq_src <= 8'h01;
        repeat (6) @(negedge pclk);
        chk({31'h0, irq_service}, 32'h1);
        run_op(4'h5, 4);
        rc(cbd_pkg::REG_SYSMODE, 32'h0);
        rc(cbd_pkg::REG_FLAGS, 32'hfc);
        @(posedge pclk);
        irq_src <= 8'h03;
        repeat (6) @(negedge pclk);
        chk({31'h0, irq_service}, 32'h0);
        rc(cbd_pkg::REG_PEND, 32'h3);
        wr(cbd_pkg::REG_SYSMODE, 32'h1);
        wr(cbd_pkg::REG_SYSMODE, 32'h0);
        repeat (2) @(negedge pclk);
        chk({31'h0, irq_service}, 32'h0);
        complete_run();
    end
    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule : cbd_exec_top_bench
`default_nettype wire
